// ### hw/alt_mode_exec.sv
// Alternate-mode shift, skip, embedded I/O, switch read and trap vectoring unit.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
module alt_mode_exec
  import alt_exec_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire panel_s panel_in,
  output io_pulse_s io_out,
  output logic [11:0] io_word
);
  // ********************************************************************
  // Functions
  // ********************************************************************
  function automatic logic in_rng(logic [11:0] v, logic [11:0] lo, logic [11:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction : in_rng
  function automatic logic is_mapped(logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= OFF_MADDR);
  endfunction : is_mapped
  // ********************************************************************
  // State
  // ********************************************************************
  panel_s pin_meta_ff, pin_ff;
  exec_e state_ff;
  logic [6:0] tmr_ff, opc;
  logic [11:0] ir_ff, ac_ff, mq_ff, mb_ff, ma_ff, io_word_ff;
  logic link_ff, flow_ff, trap_en_ff, tape_trap_ff, skip_ff, trapped_ff;
  logic [1:0] ret_inc_ff, io_step_ff;
  logic repeat_sync_flag_ff, state5_repeat_flag_ff, io_wait_flag_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  io_pulse_s io_out_ff;
  logic acc_ph, wr_en, busy, start, ibit, shift_op, trap_hit, cond, io_bit;
  logic [3:0] cnt;
  assign acc_ph = psel && penable && pready_ff;
  assign wr_en = acc_ph && pwrite && !pslverr_ff;
  assign busy = (state_ff != S_IDLE);
  assign start = wr_en && (paddr == OFF_CTRL) && pwdata[CTRL_START] && !busy;
  assign opc = ir_ff[11:5];
  assign ibit = ir_ff[4];
  assign cnt = ir_ff[3:0];
  assign shift_op = (opc == OPC_ROR) || (opc == OPC_SCR) || (opc == OPC_ROL);
  assign io_bit = mb_ff[2'd0 + io_step_ff];
  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_ff <= '0;
      pin_ff <= '0;
    end else begin
      pin_meta_ff <= panel_in;
      pin_ff <= pin_meta_ff;
    end
  end
  // ********************************************************************
  // Trap and skip decode
  // ********************************************************************
  always_comb begin
    trap_hit = 1'b0;
    if (trap_en_ff) begin
      trap_hit = in_rng(ir_ff, TR_A_LO, TR_A_HI) || in_rng(ir_ff, TR_B_LO, TR_B_HI) ||
                 in_rng(ir_ff, TR_C_LO, TR_C_HI) || in_rng(ir_ff, TR_D_LO, TR_D_HI) ||
                 in_rng(ir_ff, TR_E_LO, TR_E_HI) ||
                 (tape_trap_ff && in_rng(ir_ff, TR_T_LO, TR_T_HI));
    end
  end
  always_comb begin
    cond = 1'b0;
    if (opc == OPC_SXL) begin
      cond = (cnt < 4'd12) ? pin_ff.xl[cnt] : 1'b0;
    end else begin
      case (cnt)
        N_AZE: cond = (ac_ff == 12'h000) || (ac_ff == 12'hFFF);
        N_APO: cond = !ac_ff[11];
        N_LZE: cond = !link_ff;
        N_FLO: cond = flow_ff;
        N_QLZ: cond = !mq_ff[0];
        N_SKP: cond = 1'b1;
        default: cond = (cnt <= N_SNS_MAX) ? pin_ff.sense[3'(cnt)] : 1'b0;
      endcase
    end
  end
  // ********************************************************************
  // Sequencer, repeat flags and place counter
  // ********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= S_IDLE;
      tmr_ff <= 7'h00;
      io_step_ff <= 2'h0;
    end else begin
      case (state_ff)
        S_IDLE: begin
          if (start && !trap_hit) begin
            state_ff <= S_TP4;
          end
        end
        S_TP4: begin
          if (shift_op && (cnt != 4'h0)) begin
            state_ff <= S_PAUSE;
            tmr_ff <= RECYC_CYC - 7'h01;
          end else if (opc == OPC_LOPR && !ibit && cnt == N_IOB) begin
            state_ff <= S_IO_SHIFT;
            io_step_ff <= 2'h0;
          end else if (opc == OPC_LOPR && !ibit && (cnt == N_RSW || cnt == N_LSW)) begin
            state_ff <= S_TS5;
          end else begin
            state_ff <= S_IDLE;
          end
        end
        S_PAUSE: begin
          if (tmr_ff == 7'h00) begin
            state_ff <= S_TS5;
          end else begin
            tmr_ff <= tmr_ff - 7'h01;
          end
        end
        S_TS5: begin
          if (!shift_op || cnt == 4'h1) begin
            state_ff <= S_IDLE;
          end
        end
        S_IO_SHIFT: begin
          state_ff <= S_IO_SAMPLE;
          tmr_ff <= SAMPLE_CYC - 7'h01;
        end
        S_IO_SAMPLE: begin
          if (tmr_ff == 7'h00) begin
            state_ff <= S_IO_OFF;
            tmr_ff <= OFFIOP_CYC - 7'h01;
          end else begin
            tmr_ff <= tmr_ff - 7'h01;
          end
        end
        S_IO_OFF: begin
          if (tmr_ff == 7'h00) begin
            state_ff <= S_IO_CLK;
            tmr_ff <= IOCLK_CYC - 7'h01;
          end else begin
            tmr_ff <= tmr_ff - 7'h01;
          end
        end
        S_IO_CLK: begin
          if (tmr_ff != 7'h00) begin
            tmr_ff <= tmr_ff - 7'h01;
          end else if (io_step_ff == 2'h2) begin
            state_ff <= S_IDLE;
          end else begin
            state_ff <= S_IO_SHIFT;
            io_step_ff <= io_step_ff + 2'h1;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      repeat_sync_flag_ff <= 1'b0;
      state5_repeat_flag_ff <= 1'b0;
      io_wait_flag_ff <= 1'b0;
    end else begin
      if (state_ff == S_TP4 && shift_op && cnt != 4'h0) begin
        repeat_sync_flag_ff <= 1'b1;
      end else if (state_ff == S_TS5 && cnt == 4'h1) begin
        repeat_sync_flag_ff <= 1'b0;
      end
      if (state_ff == S_PAUSE && tmr_ff == 7'h00) begin
        state5_repeat_flag_ff <= 1'b1;
      end else if (state_ff == S_TS5 && cnt == 4'h1) begin
        state5_repeat_flag_ff <= 1'b0;
      end
      if (state_ff == S_TP4 && opc == OPC_LOPR && !ibit && cnt == N_IOB) begin
        io_wait_flag_ff <= 1'b1;
      end else if (state_ff == S_IO_CLK && tmr_ff == 7'h00 && io_step_ff == 2'h2) begin
        io_wait_flag_ff <= 1'b0;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_ff <= RST_WORD;
      mb_ff <= RST_WORD;
    end else begin
      if (wr_en && !busy && paddr == OFF_INSN) begin
        ir_ff <= pwdata[11:0];
      end else if (state_ff == S_TS5 && shift_op) begin
        ir_ff[3:0] <= cnt - 4'h1;
      end
      if (wr_en && !busy && paddr == OFF_NEXTW) begin
        mb_ff <= pwdata[11:0];
      end
    end
  end
  // ********************************************************************
  // Accumulator, MQ, link and flow
  // ********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ac_ff <= RST_WORD;
      mq_ff <= RST_WORD;
      link_ff <= 1'b0;
      flow_ff <= 1'b0;
    end else if (state_ff == S_TS5) begin
      case (opc)
        OPC_ROR: begin
          ac_ff <= {(ibit ? link_ff : mq_ff[0]), ac_ff[11:1]};
          mq_ff <= {ac_ff[0], mq_ff[11:1]};
          if (ibit) begin
            link_ff <= mq_ff[0];
          end
        end
        OPC_SCR: begin
          ac_ff <= {ac_ff[11], ac_ff[11:1]};
          mq_ff <= {ac_ff[0], mq_ff[11:1]};
          if (ibit) begin
            link_ff <= ac_ff[0];
          end
        end
        OPC_ROL: begin
          ac_ff <= {ac_ff[10:0], (ibit ? link_ff : ac_ff[11])};
          if (ibit) begin
            link_ff <= ac_ff[11];
          end
        end
        OPC_LOPR: ac_ff <= (cnt == N_RSW) ? pin_ff.right_sw : pin_ff.left_sw;
        default: ac_ff <= ac_ff;
      endcase
    end else if (wr_en && !busy) begin
      if (paddr == OFF_ACC) begin
        ac_ff <= pwdata[11:0];
      end
      if (paddr == OFF_MQ) begin
        mq_ff <= pwdata[11:0];
      end
      if (paddr == OFF_FLAGS) begin
        link_ff <= pwdata[FLG_LINK];
        flow_ff <= pwdata[FLG_FLOW];
      end
    end
  end
  // ********************************************************************
  // Skip, trap and vectoring
  // ********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_ff <= 1'b0;
      trapped_ff <= 1'b0;
      ret_inc_ff <= 2'h0;
      ma_ff <= RST_WORD;
      trap_en_ff <= 1'b0;
      tape_trap_ff <= 1'b0;
    end else begin
      if (state_ff == S_TP4 && (opc == OPC_SXL || opc == OPC_SKIP)) begin
        skip_ff <= cond ^ ibit;
      end else if (start) begin
        skip_ff <= 1'b0;
      end
      if (start) begin
        trapped_ff <= trap_hit;
        ret_inc_ff <= (ir_ff == TWO_WORD_A || ir_ff == TWO_WORD_B) ? 2'h2 : 2'h1;
        if (trap_hit) begin
          ma_ff <= VEC_TRAP;
        end
      end else if (wr_en && paddr == OFF_CTRL && pwdata[CTRL_INT] && !busy) begin
        ma_ff <= trap_en_ff ? VEC_TRAP : VEC_INT;
      end
      if (wr_en && paddr == OFF_CTRL && !busy) begin
        trap_en_ff <= pwdata[CTRL_TRAP];
        tape_trap_ff <= pwdata[CTRL_TTRAP];
      end
    end
  end
  // ********************************************************************
  // I/O pulse outputs
  // ********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_out_ff <= '0;
      io_word_ff <= RST_WORD;
    end else begin
      io_out_ff.strobe <= 1'b0;
      case (state_ff)
        S_IO_SHIFT: begin
          io_word_ff <= mb_ff;
          io_out_ff.first <= (io_step_ff == 2'h0) && mb_ff[0];
          io_out_ff.second <= (io_step_ff == 2'h1) && mb_ff[1];
          io_out_ff.fourth <= (io_step_ff == 2'h2) && mb_ff[2];
          io_out_ff.sample <= 1'b1;
        end
        S_IO_SAMPLE: io_out_ff.strobe <= (tmr_ff == 7'h00) && io_bit;
        S_IO_OFF: begin
          if (tmr_ff == 7'h00) begin
            io_out_ff <= '0;
          end
        end
        default: io_out_ff.strobe <= 1'b0;
      endcase
    end
  end
  // ********************************************************************
  // APB slave
  // ********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= psel && !penable;
      pslverr_ff <= psel && !penable && !is_mapped(paddr);
      if (psel && !penable) begin
        case (paddr)
          OFF_CTRL: prdata_ff <= {28'h0, tape_trap_ff, trap_en_ff, 2'h0};
          OFF_INSN: prdata_ff <= {20'h0, ir_ff};
          OFF_ACC: prdata_ff <= {20'h0, ac_ff};
          OFF_MQ: prdata_ff <= {20'h0, mq_ff};
          OFF_FLAGS: prdata_ff <= {30'h0, flow_ff, link_ff};
          OFF_NEXTW: prdata_ff <= {20'h0, mb_ff};
          OFF_STAT: prdata_ff <= {26'h0, ret_inc_ff, io_wait_flag_ff, trapped_ff, skip_ff, busy};
          OFF_MADDR: prdata_ff <= {20'h0, ma_ff};
          default: prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign io_out = io_out_ff;
  assign io_word = io_word_ff;
endmodule : alt_mode_exec

// ### hw/alt_exec_pkg.sv
// Constants, types and encodings shared by the alternate-mode execution block.
package alt_exec_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_MHZ = 125;
  localparam int RECYC_NS = 50;
  localparam int SAMPLE_NS = 500;
  localparam int OFFIOP_NS = 200;
  localparam int IOCLK_NS = 100;
  localparam logic [6:0] RECYC_CYC = 7'((RECYC_NS * CLK_MHZ + 999) / 1000);
  localparam logic [6:0] SAMPLE_CYC = 7'((SAMPLE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [6:0] OFFIOP_CYC = 7'((OFFIOP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [6:0] IOCLK_CYC = 7'((IOCLK_NS * CLK_MHZ + 999) / 1000);

  // ********************************************************************
  // Register map and fields
  // ********************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INSN = 8'h04;
  localparam logic [7:0] OFF_ACC = 8'h08;
  localparam logic [7:0] OFF_MQ = 8'h0C;
  localparam logic [7:0] OFF_FLAGS = 8'h10;
  localparam logic [7:0] OFF_NEXTW = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;
  localparam logic [7:0] OFF_MADDR = 8'h1C;
  localparam int CTRL_START = 0;
  localparam int CTRL_INT = 1;
  localparam int CTRL_TRAP = 2;
  localparam int CTRL_TTRAP = 3;
  localparam int FLG_LINK = 0;
  localparam int FLG_FLOW = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_SKIP = 1;
  localparam int STAT_TRAPPED = 2;
  localparam int STAT_RET = 4;
  localparam logic [11:0] RST_WORD = 12'h000;

  // ********************************************************************
  // Instruction encodings
  // ********************************************************************
  localparam logic [6:0] OPC_ROL = 7'h05;
  localparam logic [6:0] OPC_ROR = 7'h06;
  localparam logic [6:0] OPC_SCR = 7'h07;
  localparam logic [6:0] OPC_SXL = 7'h08;
  localparam logic [6:0] OPC_SKIP = 7'h09;
  localparam logic [6:0] OPC_LOPR = 7'h0A;
  localparam logic [3:0] N_SNS_MAX = 4'h5;
  localparam logic [3:0] N_AZE = 4'h8;
  localparam logic [3:0] N_APO = 4'h9;
  localparam logic [3:0] N_LZE = 4'hA;
  localparam logic [3:0] N_FLO = 4'hC;
  localparam logic [3:0] N_QLZ = 4'hD;
  localparam logic [3:0] N_SKP = 4'hE;
  localparam logic [3:0] N_IOB = 4'h0;
  localparam logic [3:0] N_RSW = 4'hE;
  localparam logic [3:0] N_LSW = 4'hF;
  localparam logic [11:0] VEC_INT = 12'h020;
  localparam logic [11:0] VEC_TRAP = 12'h060;
  localparam logic [11:0] TR_A_LO = 12'h141;
  localparam logic [11:0] TR_A_HI = 12'h14D;
  localparam logic [11:0] TR_B_LO = 12'h151;
  localparam logic [11:0] TR_B_HI = 12'h15D;
  localparam logic [11:0] TR_C_LO = 12'h160;
  localparam logic [11:0] TR_C_HI = 12'h17F;
  localparam logic [11:0] TR_D_LO = 12'h1E0;
  localparam logic [11:0] TR_D_HI = 12'h1FF;
  localparam logic [11:0] TR_E_LO = 12'h3C0;
  localparam logic [11:0] TR_E_HI = 12'h3DF;
  localparam logic [11:0] TR_T_LO = 12'h1C0;
  localparam logic [11:0] TR_T_HI = 12'h1DF;
  localparam logic [11:0] TWO_WORD_A = 12'h3C0;
  localparam logic [11:0] TWO_WORD_B = 12'h3D0;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [3:0] {
    S_IDLE, S_TP4, S_PAUSE, S_TS5, S_IO_SHIFT, S_IO_SAMPLE, S_IO_OFF, S_IO_CLK
  } exec_e;

  typedef struct packed {
    logic [11:0] xl;
    logic [5:0] sense;
    logic [11:0] right_sw;
    logic [11:0] left_sw;
  } panel_s;

  typedef struct packed {
    logic first;
    logic second;
    logic fourth;
    logic sample;
    logic strobe;
  } io_pulse_s;

endpackage : alt_exec_pkg

// ### test/alt_mode_exec_assertions.sv
// Port checker for the alternate-mode execution unit.
`timescale 1ns/10ps
module alt_exec_checker
  import alt_exec_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire io_pulse_s io_out,
  input wire logic [11:0] io_word
);
  // ******
  // Sample window counter
  // ******
  logic [7:0] win_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_ff <= 8'h00;
    end else begin
      win_ff <= io_out.sample ? win_ff + 8'h01 : 8'h00;
    end
  end
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence quiet_gap;
    !io_out.sample [*8];
  endsequence
  sequence answer;
    psel && penable && pready;
  endsequence
  a_ready_once: assert property (psel && !penable |=> answer)
    else $error("no answer in access cycle");
  a_strobe_late: assert property (io_out.strobe |-> win_ff == 8'h3F)
    else $error("strobe off time");
  a_sample_width: assert property ($fell(io_out.sample) |-> win_ff == 8'h58)
    else $error("sample window width wrong");
  a_strobe_single: assert property (io_out.strobe |=> !io_out.strobe)
    else $error("strobe longer than one cycle");
  a_restart_gap: assert property ($fell(io_out.sample) |-> quiet_gap)
    else $error("chain restarted too soon");
  a_pulse_window: assert property (io_out.first || io_out.second || io_out.fourth |-> io_out.sample)
    else $error("pulse outside sample window");
  a_first_gate: assert property (io_out.first |-> io_word[0])
    else $error("first pulse without its bit");
  a_later_gates: assert property ((io_out.second |-> io_word[1]) and (io_out.fourth |-> io_word[2]))
    else $error("later pulse without its bit");
  a_one_step: assert property ($onehot0({io_out.first, io_out.second, io_out.fourth}))
    else $error("two pulse lines at once");
  a_word_hold: assert property (io_out.sample && $past(io_out.sample) |-> $stable(io_word))
    else $error("word moved inside window");
endmodule : alt_exec_checker
bind alt_mode_exec alt_exec_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .io_out(io_out), .io_word(io_word));

// ### test/io_peripheral.sv
// Peripheral model that takes the I/O pulses of the execution unit.
`timescale 1ns/10ps
module io_peripheral
  import alt_exec_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire io_pulse_s io_out,
  input wire logic [11:0] io_word,
  output int strobe_total,
  output logic [2:0] steps_seen,
  output logic [11:0] last_word
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_total <= 0;
      steps_seen <= 3'h0;
      last_word <= 12'h000;
    end else if (clr) begin
      strobe_total <= 0;
      steps_seen <= 3'h0;
    end else begin
      if (io_out.strobe) begin
        strobe_total <= strobe_total + 1;
        last_word <= io_word;
      end
      steps_seen <= steps_seen | {io_out.fourth, io_out.second, io_out.first};
    end
  end
endmodule : io_peripheral

// ### test/alt_mode_shift_skip_iot_exec_bench.sv
// Self-checking bench for the alternate-mode execution unit.
`timescale 1ns/10ps
module alt_mode_shift_skip_iot_exec_bench
  import alt_exec_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, pclr, rerr, l, f;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] io_word, pword, a, q, w, av;
  logic [2:0] steps;
  logic [3:0] codes[6] = '{4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE};
  logic [11:0] tc[10] = '{12'h14E, 12'h1C0, 12'h1DF, 12'h141, 12'h15D, 12'h160, 12'h1FF, 12'h3DF, 12'h3C0, 12'h3D0};
  panel_s panel_in;
  io_pulse_s io_out;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  int strobes;
  alt_mode_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .panel_in(panel_in), .io_out(io_out), .io_word(io_word));
  io_peripheral peer (.pclk(pclk), .presetn(presetn), .clr(pclr), .io_out(io_out), .io_word(io_word),
    .strobe_total(strobes), .steps_seen(steps), .last_word(pword));
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      print_verdict();
    end
  end
  // ******
  // Bus and model tasks
  // ******
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) err_total++;
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    check(rd, exp);
  endtask : rdchk
  task automatic run(input logic [11:0] ins, input logic [3:0] ctl);
    int n;
    n = 0;
    apb(1'b1, OFF_CTRL, {28'h0, ctl});
    apb(1'b1, OFF_INSN, {20'h0, ins});
    apb(1'b1, OFF_CTRL, {28'h0, ctl | 4'h1});
    do begin
      apb(1'b0, OFF_STAT, 32'h0);
      n++;
    end while (rd[STAT_BUSY] !== 1'b0 && n < 200);
    if (rd[STAT_BUSY] !== 1'b0) err_total++;
  endtask : run
  task automatic load(input logic [11:0] v);
    a = v;
    q = 12'($urandom);
    l = 1'($urandom);
    f = 1'($urandom);
    apb(1'b1, OFF_ACC, {20'h0, a});
    apb(1'b1, OFF_MQ, {20'h0, q});
    apb(1'b1, OFF_FLAGS, {30'h0, f, l});
  endtask : load
  task automatic shift(input logic [6:0] op, input logic ib, input logic [3:0] n);
    load(12'($urandom));
    run({op, ib, n}, 4'h0);
    repeat (n) begin
      if (op == 7'h06 && ib) {l, a, q} = {q[0], l, a, q[11:1]};
      else if (op == 7'h06) {a, q} = {q[0], a, q[11:1]};
      else if (op == 7'h07) begin
        if (ib) l = a[0];
        {a, q} = {a[11], a, q[11:1]};
      end else if (ib) {l, a} = {a, l};
      else a = {a[10:0], a[11]};
    end
    rdchk(OFF_ACC, {20'h0, a});
    rdchk(OFF_MQ, {20'h0, q});
    rdchk(OFF_FLAGS, {30'h0, f, l});
    rdchk(OFF_INSN, {20'h0, op, ib, 4'h0});
  endtask : shift
  task automatic skip(input logic [6:0] op, input logic [3:0] n, input logic [11:0] v);
    logic c;
    logic ib;
    ib = 1'($urandom);
    panel_in <= panel_s'(42'({$urandom(), $urandom()}));
    load(v);
    run({op, ib, n}, 4'h0);
    if (op == 7'h08) c = n < 4'hC ? panel_in.xl[n] : 1'b0;
    else case (n)
      4'h8: c = a == 12'h000 || a == 12'hFFF;
      4'h9: c = !a[11];
      4'hA: c = !l;
      4'hC: c = f;
      4'hD: c = !q[0];
      4'hE: c = 1'b1;
      default: c = n <= 4'h5 ? panel_in.sense[n] : 1'b0;
    endcase
    apb(1'b0, OFF_STAT, 32'h0);
    check({31'h0, rd[STAT_SKIP]}, {31'h0, c ^ ib});
  endtask : skip
  // ******
  // Main sequence
  // ******
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pclr = 1'b0;
    panel_in = '0;
    void'($urandom(16137));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(OFF_ACC, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, rerr}, 32'h1);
    $display("reset and bus test done");
    shift(7'h06, 1'b0, 4'h0);
    for (int i = 0; i < 6; i++) begin
      shift(i < 2 ? 7'h06 : i < 4 ? 7'h07 : 7'h05, 1'(i), i == 0 ? 4'hF : 4'($urandom_range(15, 1)));
    end
    $display("shift test done");
    for (int r = 0; r < 4; r++) begin
      av = r == 0 ? 12'h000 : r == 1 ? 12'hFFF : 12'($urandom);
      skip(7'h08, 4'($urandom), av);
      skip(7'h09, 4'($urandom_range(5)), av);
      foreach (codes[i]) skip(7'h09, codes[i], av);
    end
    $display("skip test done");
    panel_in <= panel_s'(42'({$urandom(), $urandom()}));
    run(12'h14E, 4'h0);
    rdchk(OFF_ACC, {20'h0, panel_in.right_sw});
    run(12'h14F, 4'h0);
    rdchk(OFF_ACC, {20'h0, panel_in.left_sw});
    $display("switch test done");
    for (int r = 0; r < 3; r++) begin
      w = {9'($urandom), r == 0 ? 3'h7 : r == 1 ? 3'h5 : 3'($urandom)};
      apb(1'b1, OFF_NEXTW, {20'h0, w});
      pclr <= 1'b1;
      @(posedge pclk);
      pclr <= 1'b0;
      run(12'h140, 4'h0);
      check({29'h0, steps}, {29'h0, w[2:0]});
      check(strobes, $countones(w[2:0]));
      check({31'h0, rd[3]}, 32'h0);
      if (w[2:0] != 3'h0) check({20'h0, pword}, {20'h0, w});
    end
    $display("io test done");
    for (int i = 0; i < 10; i++) begin
      run(tc[i], i == 2 ? 4'hC : 4'h4);
      check({31'h0, rd[STAT_TRAPPED]}, {31'h0, 1'(i >= 2)});
      if (i >= 2) check({30'h0, rd[5:4]}, i >= 8 ? 32'h2 : 32'h1);
      if (i >= 2) rdchk(OFF_MADDR, 32'h060);
    end
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h2);
    rdchk(OFF_MADDR, 32'h020);
    apb(1'b1, OFF_CTRL, 32'h4);
    apb(1'b1, OFF_CTRL, 32'h6);
    rdchk(OFF_MADDR, 32'h060);
    $display("trap test done");
    print_verdict();
  end
endmodule : alt_mode_shift_skip_iot_exec_bench
